/* File: bench/tbtc_partner.sv */
// Stop-mark logic model facing the timing chain
`timescale 1ns/100ps
`default_nettype none
module tbtc_partner (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic stop_enable,
	input wire logic bit_tick,
	input wire logic end_now,
	input wire logic reset_now,
	output logic char_end_n,
	output logic char_reset
);
	////////////////////////////////////////////////////////////
	// Bench may end a character early to reach the gate clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			char_end_n <= 1'b1;
			char_reset <= 1'b0;
		end
		else
		begin
			char_end_n <= !(stop_enable || end_now);
			char_reset <= reset_now || (stop_enable && bit_tick);
		end
	end
endmodule
`default_nettype wire

/* File: bench/tbtc_top_tb.sv */
// Self-checking bench for the baud timing chain
`timescale 1ns/100ps
`default_nettype none
module tbtc_top_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready, pslverr, time_base, timing_gate, master_tick, bit_rate, bit_tick;
	logic [3:0] units, tens;
	logic [4:0] bit_gate;
	logic stop_enable, char_advance, char_end_n, char_reset;
	logic end_now = 1'b0;
	logic reset_now = 1'b0;
	logic [32:0] exp_q[$];
	logic [32:0] mon_e;
	logic [31:0] seed = 32'h1B;
	int miscompares = 0;
	int checks_done = 0;

	always #50 pclk = ~pclk;

	tbtc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .char_end_n(char_end_n), .char_reset(char_reset),
		.time_base(time_base), .timing_gate(timing_gate), .master_tick(master_tick),
		.bit_rate(bit_rate), .bit_tick(bit_tick), .units(units), .tens(tens),
		.bit_gate(bit_gate), .stop_enable(stop_enable), .char_advance(char_advance));

	tbtc_partner partner_u (.pclk(pclk), .presetn(presetn), .stop_enable(stop_enable),
		.bit_tick(bit_tick), .end_now(end_now), .reset_now(reset_now),
		.char_end_n(char_end_n), .char_reset(char_reset));

	////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Entered just after a rising edge; leaves one idle edge behind
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		exp_q.push_back(e);
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		check("pready", {31'h0, pready}, 32'h1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Cycles until the signal is next seen rising, bounded
	task automatic wait_hi(ref logic s, output int n);
		n = 0;
		while (s !== 1'b0 && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
		while (s !== 1'b1 && n < 3000)
		begin
			@(posedge pclk);
			n++;
		end
	endtask

	////////////////////////////////////////////////////////////
	always @(posedge pclk)
		if (psel && penable && pready)
		begin
			mon_e = exp_q.pop_front();
			check("pslverr", {31'h0, pslverr}, {31'h0, mon_e[32]});
			if (!pwrite)
				check("prdata", prdata, mon_e[31:0]);
		end

	initial
	begin
		#(98000 * 100);
		miscompares++;
		$display("CHECK FAILED watchdog expected finish seen hang");
		test_done();
	end

	////////////////////////////////////////////////////////////
	initial
	begin
		int n, p, e, r, k;
		static int dv[7] = '{256, 16, 192, 16, 16, 8, 128};
		static logic [63:0] hz[7] = '{tbtc_pkg::OSC_HZ_1920K, tbtc_pkg::OSC_HZ_145K6,
			tbtc_pkg::OSC_HZ_1920K, tbtc_pkg::OSC_HZ_181K8, tbtc_pkg::OSC_HZ_195K584,
			tbtc_pkg::OSC_HZ_118K72, tbtc_pkg::OSC_HZ_1920K};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, tbtc_pkg::REG_CTRL, xs(), 33'h0);
		apb(1'b0, tbtc_pkg::REG_STATUS, xs(), 33'h1);
		apb(1'b1, 8'h0C, xs(), 33'h1_0000_0000);
		apb(1'b0, 8'h01, xs(), 33'h1_0000_0000);
		// Oscillators are phase accumulators, so allow a couple of cycles jitter
		for (r = 0; r < 7; r++)
		begin
			apb(1'b1, tbtc_pkg::REG_CTRL, 32'(r), 33'h0);
			wait_hi(time_base, n);
			wait_hi(time_base, p);
			e = int'(real'(tbtc_pkg::CLK_HZ) * dv[r] / real'(hz[r]));
			check("tb_period", (p - e <= 2 && e - p <= 2) ? e : p, e);
		end
		apb(1'b1, tbtc_pkg::REG_CTRL, 32'h7, 33'h0);
		wait_hi(master_tick, n);
		check("no_source", n, 3000);
		apb(1'b1, tbtc_pkg::REG_CTRL, 32'hE, 33'h0);
		reset_now <= 1'b1;
		@(posedge pclk);
		reset_now <= 1'b0;
		repeat (3) @(posedge pclk);
		end_now <= 1'b1;
		for (k = 1; k <= 50; k++)
		begin
			wait_hi(master_tick, p);
			if (k > 1)
				check("tick_gap", (p + 6 >= 1330 && p + 6 <= 1336) ? 1333 : p + 6, 1333);
			repeat (6) @(posedge pclk);
			check("count", {24'h0, tens, units}, 32'((k / 10) * 16 + k % 10));
			check("gate", {31'h0, timing_gate}, {31'h0, k < 50});
		end
		check("bit_rate", {31'h0, bit_rate}, 32'h1);
		wait_hi(master_tick, n);
		check("gate_shut", n, 3000);
		apb(1'b0, tbtc_pkg::REG_STATUS, xs(), 33'h06);
		check("bit_outs", {24'h0, bit_tick, char_advance, stop_enable, bit_gate}, 32'h0);
		end_now <= 1'b0;
		@(posedge pclk);
		apb(1'b1, tbtc_pkg::REG_CTRL, 32'h1E, 33'h0);
		repeat (4) @(posedge pclk);
		check("trigger", {31'h0, timing_gate}, 32'h1);
		apb(1'b0, tbtc_pkg::REG_COUNT, xs(), 33'h50);
		test_done();
	end
endmodule
`default_nettype wire

/* File: rtl/tbtc_top.sv */
// Telegraph baud timing chain: sources, divider, timing control, decades, bit counter
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module tbtc_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic char_end_n,
	input wire logic char_reset,
	output logic time_base,
	output logic timing_gate,
	output logic master_tick,
	output logic bit_rate,
	output logic bit_tick,
	output logic [3:0] units,
	output logic [3:0] tens,
	output logic [4:0] bit_gate,
	output logic stop_enable,
	output logic char_advance
);
	////////////////////////////////////////////////////////////////////////
	// Register bus
	tbtc_pkg::tbtc_rate_e rate;
	logic single;
	logic trig;
	logic gate;
	logic halve;
	logic [3:0] unit_q;
	logic [3:0] ten_q;
	logic [3:0] bit_count;
	logic m_level;
	logic setup;
	logic wr;
	logic mapped;
	logic [31:0] rd_mux;

	assign setup = psel & ~penable;
	assign wr = psel & penable & pready & pwrite;
	assign m_level = ten_q >= tbtc_pkg::DEC_HALF;

	always_comb
	begin
		mapped = paddr[1:0] == 2'h0;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			tbtc_pkg::REG_CTRL: rd_mux = {28'h000_0000, single, rate};
			tbtc_pkg::REG_STATUS: rd_mux = {24'h00_0000, bit_count == tbtc_pkg::BIT_STOP,
				bit_count, m_level, halve, gate};
			tbtc_pkg::REG_COUNT: rd_mux = {24'h00_0000, ten_q, unit_q};
			default: mapped = 1'b0;
		endcase
	end

	// One wait-free access: answer is registered during setup
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end
		else
		begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			prdata <= setup ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rate <= tbtc_pkg::tbtc_rate_e'(tbtc_pkg::CTRL_RATE_RST);
			single <= tbtc_pkg::CTRL_SINGLE_RST;
			trig <= 1'b0;
		end
		else
		begin
			trig <= wr && paddr == tbtc_pkg::REG_CTRL && pwdata[tbtc_pkg::CTRL_TRIG_BIT];
			if (wr && paddr == tbtc_pkg::REG_CTRL)
			begin
				rate <= tbtc_pkg::tbtc_rate_e'(pwdata[tbtc_pkg::CTRL_RATE_MSB:0]);
				single <= pwdata[tbtc_pkg::CTRL_SINGLE_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Rate selection
	logic [2:0] osc_sel;
	logic [7:0] step;
	logic div50;
	logic tap_hi;

	always_comb
	begin
		osc_sel = tbtc_pkg::OSC_1920K;
		step = tbtc_pkg::STEP_STAGE1;
		div50 = 1'b0;
		tap_hi = 1'b1;
		unique case (rate)
			tbtc_pkg::TBTC_R37_5: tap_hi = 1'b1;
			tbtc_pkg::TBTC_R75: tap_hi = 1'b0;
			tbtc_pkg::TBTC_R50: div50 = 1'b1;
			tbtc_pkg::TBTC_R45_5:
			begin
				osc_sel = tbtc_pkg::OSC_145K6;
				step = tbtc_pkg::STEP_STAGE5;
			end
			tbtc_pkg::TBTC_R61_12:
			begin
				osc_sel = tbtc_pkg::OSC_195K584;
				step = tbtc_pkg::STEP_STAGE5;
			end
			tbtc_pkg::TBTC_R56_8:
			begin
				osc_sel = tbtc_pkg::OSC_181K8;
				step = tbtc_pkg::STEP_STAGE5;
			end
			tbtc_pkg::TBTC_R74_2:
			begin
				osc_sel = tbtc_pkg::OSC_118K72;
				step = tbtc_pkg::STEP_STAGE6;
			end
			// Unused code powers no source and freezes the chain
			default: osc_sel = tbtc_pkg::OSC_NONE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Oscillators as phase accumulators; unselected ones sit idle
	logic [tbtc_pkg::OSC_N-1:0] src_on;
	logic [tbtc_pkg::OSC_N-1:0] osc_tick;
	logic src_tick;

	for (genvar i = 0; i < tbtc_pkg::OSC_N; i++)
	begin : g_osc
		logic [31:0] acc;
		logic [32:0] sum;
		assign src_on[i] = osc_sel == 3'(i);
		assign sum = {1'b0, acc} + {1'b0, tbtc_pkg::OSC_INC[i]};
		assign osc_tick[i] = sum[32] & src_on[i];
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				acc <= 32'h0000_0000;
			else
				acc <= src_on[i] ? sum[31:0] : 32'h0000_0000;
		end
	end

	assign src_tick = |osc_tick;

	////////////////////////////////////////////////////////////////////////
	// Eight-stage divider and time base
	logic [7:0] div;
	logic [7:0] next_div;
	logic tb_prev;
	logic tap;
	logic tb_rise;
	logic rate_new;

	// Restart the chain on a rate change so the mod-3 pair never starts at 3
	assign rate_new = wr && paddr == tbtc_pkg::REG_CTRL && pwdata[2:0] != 3'(rate);

	always_comb
	begin
		next_div = div;
		if (src_tick)
		begin
			if (div50)
			begin
				next_div[5:0] = div[5:0] + 6'h01;
				if (div[5:0] == tbtc_pkg::DIV50_LOW_MAX)
					next_div[7:6] = div[7:6] == tbtc_pkg::DIV50_MOD_MAX ? 2'h0 : div[7:6] + 2'h1;
			end
			else
				next_div = div + step;
		end
	end

	// 50 baud output is the high third of the mod-3 pair
	assign tap = div50 ? div[7] : (tap_hi ? div[7] : div[6]);
	assign tb_rise = tap & ~tb_prev;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div <= 8'h00;
			tb_prev <= 1'b0;
		end
		else
		begin
			div <= rate_new ? 8'h00 : next_div;
			tb_prev <= tap;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Timing control
	logic next_gate;
	logic mtick;
	logic btick;

	always_comb
	begin
		if (!single)
			next_gate = 1'b1;
		else if (trig)
			next_gate = 1'b1;
		else if (gate && !char_end_n && m_level)
			next_gate = 1'b0;
		else
			next_gate = gate;
	end

	assign mtick = gate & tb_rise & ~halve & ~char_reset;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gate <= 1'b0;
			halve <= 1'b0;
		end
		else
		begin
			gate <= next_gate;
			if (char_reset)
				halve <= 1'b0;
			else if (gate && tb_rise)
				halve <= ~halve;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Divide-by-100 and bit counter
	assign btick = mtick && unit_q == tbtc_pkg::DEC_MAX && ten_q == tbtc_pkg::DEC_MAX;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			unit_q <= 4'h0;
			ten_q <= 4'h0;
		end
		else if (char_reset)
		begin
			unit_q <= 4'h0;
			ten_q <= 4'h0;
		end
		else if (mtick)
		begin
			unit_q <= unit_q == tbtc_pkg::DEC_MAX ? 4'h0 : unit_q + 4'h1;
			if (unit_q == tbtc_pkg::DEC_MAX)
				ten_q <= ten_q == tbtc_pkg::DEC_MAX ? 4'h0 : ten_q + 4'h1;
		end
	end

	// Counter holds at the stop count until the character reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bit_count <= 4'h0;
		else if (char_reset)
			bit_count <= 4'h0;
		else if (btick && bit_count != tbtc_pkg::BIT_STOP)
			bit_count <= bit_count + 4'h1;
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs, one cycle behind internal state
	for (genvar g = 0; g < tbtc_pkg::BIT_GATES; g++)
	begin : g_gate
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				bit_gate[g] <= 1'b0;
			else
				bit_gate[g] <= bit_count == 4'(g + 1);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			time_base <= 1'b0;
			timing_gate <= 1'b0;
			master_tick <= 1'b0;
			bit_rate <= 1'b0;
			bit_tick <= 1'b0;
			units <= 4'h0;
			tens <= 4'h0;
			stop_enable <= 1'b0;
			char_advance <= 1'b0;
		end
		else
		begin
			time_base <= tap;
			timing_gate <= gate;
			master_tick <= mtick;
			bit_rate <= m_level;
			bit_tick <= btick;
			units <= unit_q;
			tens <= ten_q;
			stop_enable <= bit_count == tbtc_pkg::BIT_STOP;
			char_advance <= btick && bit_count == tbtc_pkg::BIT_STOP - 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_src_one;
		$onehot0(src_on) && ((osc_tick & ~src_on) == '0);
	endproperty
	a_src_one: assert property (p_src_one) else $error("more than one source live");

	property p_div50;
		div50 |-> div[7:6] != 2'h3;
	endproperty
	a_div50: assert property (p_div50) else $error("50 baud stage pair left mod 3");

	property p_free_gate;
		!single |=> gate ##1 timing_gate;
	endproperty
	a_free_gate: assert property (p_free_gate) else $error("free run gate closed");

	property p_trig_set;
		single && trig |=> gate;
	endproperty
	a_trig_set: assert property (p_trig_set) else $error("trigger did not open gate");

	property p_clear;
		single && !trig && gate && !char_end_n && m_level |=> !gate;
	endproperty
	a_clear: assert property (p_clear) else $error("gate not closed at half bit");

	property p_hold;
		single && !trig && gate && (char_end_n || !m_level) |=> gate;
	endproperty
	a_hold: assert property (p_hold) else $error("gate closed early");

	property p_master;
		mtick |-> gate && !halve ##1 halve;
	endproperty
	a_master: assert property (p_master) else $error("x100 tick without open gate");

	sequence s_units_end;
		mtick && unit_q == tbtc_pkg::DEC_MAX && !char_reset;
	endsequence
	property p_decade;
		s_units_end |=> unit_q == 4'h0 &&
			ten_q == ($past(ten_q) == tbtc_pkg::DEC_MAX ? 4'h0 : $past(ten_q) + 4'h1);
	endproperty
	a_decade: assert property (p_decade) else $error("decade carry wrong");

	property p_range;
		unit_q <= tbtc_pkg::DEC_MAX && ten_q <= tbtc_pkg::DEC_MAX;
	endproperty
	a_range: assert property (p_range) else $error("decade out of BCD range");

	property p_stop_hold;
		bit_count == tbtc_pkg::BIT_STOP && !char_reset |=> bit_count == tbtc_pkg::BIT_STOP
			##1 stop_enable;
	endproperty
	a_stop_hold: assert property (p_stop_hold) else $error("bit counter left stop count");

	property p_bit_step;
		btick && !char_reset && bit_count < tbtc_pkg::BIT_STOP |=>
			bit_count == $past(bit_count) + 4'h1;
	endproperty
	a_bit_step: assert property (p_bit_step) else $error("bit tick did not step counter");
endmodule
`default_nettype wire

/* File: shared/tbtc_pkg.sv */
// Constants and types for the telegraph baud timing chain
`default_nettype none
package tbtc_pkg;
	// Register offsets (byte addresses on APB)
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_COUNT = 8'h08;
	// CTRL fields
	localparam int CTRL_RATE_MSB = 2;
	localparam int CTRL_SINGLE_BIT = 3;
	localparam int CTRL_TRIG_BIT = 4;
	localparam logic [2:0] CTRL_RATE_RST = 3'h0;
	localparam logic CTRL_SINGLE_RST = 1'b0;
	// System clock and oscillator frequencies in Hz
	localparam logic [63:0] CLK_HZ = 64'h0000_0000_0098_9680;
	localparam logic [63:0] OSC_HZ_1920K = 64'h0000_0000_001D_4C00;
	localparam logic [63:0] OSC_HZ_145K6 = 64'h0000_0000_0002_38C0;
	localparam logic [63:0] OSC_HZ_181K8 = 64'h0000_0000_0002_C628;
	localparam logic [63:0] OSC_HZ_195K584 = 64'h0000_0000_0002_FC00;
	localparam logic [63:0] OSC_HZ_118K72 = 64'h0000_0000_0001_CFC0;
	localparam int OSC_N = 5;
	// Oscillator index; OSC_NONE powers nothing
	localparam logic [2:0] OSC_1920K = 3'h0;
	localparam logic [2:0] OSC_145K6 = 3'h1;
	localparam logic [2:0] OSC_181K8 = 3'h2;
	localparam logic [2:0] OSC_195K584 = 3'h3;
	localparam logic [2:0] OSC_118K72 = 3'h4;
	localparam logic [2:0] OSC_NONE = 3'h7;
	// Divider entry steps: first, fifth and sixth stage
	localparam logic [7:0] STEP_STAGE1 = 8'h01;
	localparam logic [7:0] STEP_STAGE5 = 8'h10;
	localparam logic [7:0] STEP_STAGE6 = 8'h20;
	localparam logic [5:0] DIV50_LOW_MAX = 6'h3F;
	localparam logic [1:0] DIV50_MOD_MAX = 2'h2;
	// Decade and bit counter figures
	localparam logic [3:0] DEC_MAX = 4'h9;
	localparam logic [3:0] DEC_HALF = 4'h5;
	localparam logic [3:0] BIT_STOP = 4'h6;
	localparam int BIT_GATES = 5;

	typedef enum logic [2:0] {
		TBTC_R37_5 = 3'h0,
		TBTC_R45_5 = 3'h1,
		TBTC_R50 = 3'h2,
		TBTC_R56_8 = 3'h3,
		TBTC_R61_12 = 3'h4,
		TBTC_R74_2 = 3'h5,
		TBTC_R75 = 3'h6
	} tbtc_rate_e;

	// Phase step per system clock for a source of the given frequency
	function automatic logic [31:0] tbtc_inc(input logic [63:0] hz);
		logic [63:0] t;
		t = (hz << 32) / CLK_HZ;
		return t[31:0];
	endfunction

	localparam logic [OSC_N-1:0][31:0] OSC_INC = {
		tbtc_inc(OSC_HZ_118K72),
		tbtc_inc(OSC_HZ_195K584),
		tbtc_inc(OSC_HZ_181K8),
		tbtc_inc(OSC_HZ_145K6),
		tbtc_inc(OSC_HZ_1920K)
	};
endpackage
`default_nettype wire
